//--- verilog/pvs_pkg.sv
// Package: register map, field layout, reset values and timing counts
package pvs_pkg;

   // ****************************************************************
   // Register indices and byte addresses
   // ****************************************************************
   localparam int ADDR_W = 8;
   localparam logic [4:0] IDX_SPECIAL_CTRL = 5'h1B;
   localparam logic [4:0] IDX_IRQ_FLAGS = 5'h1D;
   localparam logic [4:0] IDX_IRQ_MASK = 5'h1E;
   localparam logic [4:0] IDX_PHY_STATUS = 5'h1F;
   localparam logic [ADDR_W-1:0] ADDR_SPECIAL_CTRL =
      {1'b0, IDX_SPECIAL_CTRL, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_IRQ_FLAGS = {1'b0, IDX_IRQ_FLAGS, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = {1'b0, IDX_IRQ_MASK, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_PHY_STATUS =
      {1'b0, IDX_PHY_STATUS, 2'b00};

   // ****************************************************************
   // Field positions and fixed values
   // ****************************************************************
   localparam int POS_PLL_FORCE = 10;
   localparam int POS_POLARITY = 4;
   localparam logic [3:0] CTRL_FIXED_LOW = 4'hB;
   localparam int POS_IRQ_ENERGY = 7;
   localparam int POS_IRQ_AUTONEG = 6;
   localparam int POS_IRQ_REMOTE = 5;
   localparam int POS_IRQ_LINKDOWN = 4;
   localparam int POS_IRQ_ACK = 3;
   localparam int POS_IRQ_PARDET = 2;
   localparam int POS_IRQ_PAGE = 1;
   localparam int POS_AUTODONE = 12;
   localparam int POS_SPEED_LSB = 2;
   localparam int POS_STS_RSV_LSB = 5;

   // ****************************************************************
   // Reset values and speed codes
   // ****************************************************************
   localparam logic PLL_FORCE_RESET = 1'b0;
   localparam logic [6:0] STS_RSV_RESET = 7'h02;
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic ENERGY_RESET = 1'b1;
   localparam logic [2:0] SPD_10_HALF = 3'h1;
   localparam logic [2:0] SPD_10_FULL = 3'h5;
   localparam logic [2:0] SPD_100_HALF = 3'h2;
   localparam logic [2:0] SPD_100_FULL = 3'h6;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLK_HZ = 100_000_000;
   localparam int ENERGY_TIMEOUT_MS = 256;
   localparam int ENERGY_TIMEOUT_CYC = ENERGY_TIMEOUT_MS * (CLK_HZ / 1000);

endpackage

//--- verilog/pvs_energy_timer.sv
// Line energy watchdog: drops the energy status after a quiet period
`timescale 1ns/10ps
`default_nettype none
module pvs_energy_timer
   import pvs_pkg::*;
#(
   parameter int TIMEOUT = ENERGY_TIMEOUT_CYC,
   parameter int CNT_W = 25
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // Line side
   input wire logic energySeen,
   // Status
   output logic line_energy_present
);

   localparam logic [CNT_W-1:0] LAST = CNT_W'(TIMEOUT - 1);

   logic [CNT_W-1:0] quietCnt_reg;
   logic line_energy_present_reg;

   // Quiet counter restarts on every sign of energy, parks at the end
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         quietCnt_reg <= '0;
      end else if (energySeen) begin
         quietCnt_reg <= '0;
      end else if (quietCnt_reg != LAST) begin
         quietCnt_reg <= quietCnt_reg + 1'b1;
      end
   end

   // Status; soft reset is not wired here so it cannot disturb it
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         line_energy_present_reg <= ENERGY_RESET;
      end else if (energySeen) begin
         line_energy_present_reg <= 1'b1;
      end else if (quietCnt_reg == LAST) begin
         line_energy_present_reg <= 1'b0; // [RULE10]
      end
   end

   assign line_energy_present = line_energy_present_reg;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   // ****************************************************************
   // Checks
   // ****************************************************************
   chk_energy_fall: assert property ( // [RULE10]
      $fell(line_energy_present) |-> $past(quietCnt_reg) == LAST && !$past(energySeen))
      else $error("energy status fell before the quiet time");
   chk_energy_seen: assert property ( // [RULE10]
      energySeen |=> line_energy_present && quietCnt_reg == '0)
      else $error("energy seen but status not set");
   cov_energy_lost: cover property ($fell(line_energy_present));

endmodule
`default_nettype wire

//--- verilog/pvs_regs.sv
// PHY vendor status, interrupt source/mask registers behind APB
//
// Behaviour
// [RULE1] PLL force bit 10 holds 10 Mb receive PLL on reference, blocks receive.
// [RULE2] Control bit 4 shows 10BASE-T receive polarity, reversed is 1, resets 0.
// [RULE3] Control bits 3:0 always read 1011b; writes to them do nothing.
// [RULE4] Source bits 7, 6, 5 latch energy, autoneg done, remote fault events.
// [RULE5] Source bits 4..1 latch link down, ack, parallel fault, page received.
// [RULE6] Mask holds bits 7-0 reset 0, one enables a source; 15-8 read zero.
// [RULE7] Status bit 12 reads one once auto-negotiation has finished, else zero.
// [RULE8] Status bits 4-2 report resolved speed and duplex codes.
// [RULE9] Software writes 0000010b to status bits 11-5 and ignores them.
// [RULE10] Energy status falls after 256 ms quiet, set by reset, soft reset immune.
// [RULE11] Latched source bits hold until read, then clear unless still active; a write of ones also clears them here.
// [RULE12] Interrupt output is high while any enabled source bit is set.
//
// Chosen here: register access over APB.
`timescale 1ns/10ps
`default_nettype none
module pvs_regs
   import pvs_pkg::*;
#(
   parameter int ENERGY_TIMEOUT_CYCLES = ENERGY_TIMEOUT_CYC
) (
   // Clock and resets
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic softRst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // PHY state from the line side
   input wire logic lineEnergySeen,
   input wire logic polarityReversed,
   input wire logic autonegDone,
   input wire logic [2:0] speedDuplex,
   input wire logic remoteFault,
   input wire logic linkUp,
   input wire logic partnerAck,
   input wire logic parallelFault,
   input wire logic pageReceived,
   // Controls and status toward the PHY and host
   output logic rxPllRefLockForce,
   output logic rx10mReceiveEnable,
   output logic lineEnergyPresent,
   output logic irqOut
);

   // ****************************************************************
   // Address decode
   // ****************************************************************

   // Decode used by the setup capture and by the access side effects
   function automatic logic isReg(input logic [ADDR_W-1:0] a,
                                  input logic [ADDR_W-1:0] r);
      isReg = (a == r);
   endfunction

   logic setupPhase;
   logic accessPhase;
   logic mapped;
   logic wrAccess;
   logic rdAccess;

   assign setupPhase = psel && !penable;
   assign accessPhase = psel && penable;
   assign mapped = isReg(paddr, ADDR_SPECIAL_CTRL) ||
                   isReg(paddr, ADDR_IRQ_FLAGS) ||
                   isReg(paddr, ADDR_IRQ_MASK) ||
                   isReg(paddr, ADDR_PHY_STATUS);
   // Zero wait states: every access completes in its first access cycle
   assign pready = 1'b1;
   assign pslverr = accessPhase && !mapped;
   assign wrAccess = accessPhase && pwrite && mapped;
   assign rdAccess = accessPhase && !pwrite && mapped;

   // ****************************************************************
   // Control registers
   // ****************************************************************
   logic pllForce_reg;
   logic [6:0] stsRsv_reg;
   logic [7:0] mask_reg;

   // PLL force survives soft reset, only hardware reset clears it
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         pllForce_reg <= PLL_FORCE_RESET;
      end else if (wrAccess && isReg(paddr, ADDR_SPECIAL_CTRL)) begin
         pllForce_reg <= pwdata[POS_PLL_FORCE]; // [RULE1]
      end
   end

   assign rxPllRefLockForce = pllForce_reg; // [RULE1]
   // While forced the 10 Mb receiver is held off, no packets pass
   assign rx10mReceiveEnable = !pllForce_reg; // [RULE1]

   // Reserved status field is stored so software can read back its write
   always_ff @(posedge clk_sys) begin
      if (!nrst || softRst) begin
         stsRsv_reg <= STS_RSV_RESET; // [RULE9]
      end else if (wrAccess && isReg(paddr, ADDR_PHY_STATUS)) begin
         stsRsv_reg <= pwdata[POS_STS_RSV_LSB +: 7];
      end
   end

   // Interrupt enables; upper byte is not stored at all
   always_ff @(posedge clk_sys) begin
      if (!nrst || softRst) begin
         mask_reg <= MASK_RESET;
      end else if (wrAccess && isReg(paddr, ADDR_IRQ_MASK)) begin
         mask_reg <= pwdata[7:0]; // [RULE6]
      end
   end

   // ****************************************************************
   // Sampled PHY state and event detection
   // ****************************************************************
   logic polarity_reg;
   logic autodone_reg;
   logic [2:0] speed_reg;
   logic line_energy_present;
   logic energyOnDly_reg;
   logic autodoneDly_reg;

   pvs_energy_timer #(
      .TIMEOUT(ENERGY_TIMEOUT_CYCLES),
      .CNT_W(25)
   ) u_energy (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .energySeen(lineEnergySeen),
      .line_energy_present(line_energy_present)
   );

   assign lineEnergyPresent = line_energy_present;

   // Registered line state keeps read data and events in step
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         polarity_reg <= 1'b0;
         autodone_reg <= 1'b0;
         speed_reg <= SPD_10_HALF;
      end else begin
         polarity_reg <= polarityReversed; // [RULE2]
         autodone_reg <= autonegDone; // [RULE7]
         speed_reg <= speedDuplex; // [RULE8]
      end
   end

   // Edge history for the two events that are level states
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         energyOnDly_reg <= ENERGY_RESET;
         autodoneDly_reg <= 1'b0;
      end else begin
         energyOnDly_reg <= line_energy_present;
         autodoneDly_reg <= autodone_reg;
      end
   end

   // Energy and autoneg use rising edges, else a steady state would
   // re-latch forever; the rest latch while their condition holds
   logic [7:0] setVec;
   always_comb begin
      setVec = 8'h00;
      setVec[POS_IRQ_ENERGY] = line_energy_present && !energyOnDly_reg; // [RULE4]
      setVec[POS_IRQ_AUTONEG] = autodone_reg && !autodoneDly_reg; // [RULE4]
      setVec[POS_IRQ_REMOTE] = remoteFault; // [RULE4]
      setVec[POS_IRQ_LINKDOWN] = !linkUp; // [RULE5]
      setVec[POS_IRQ_ACK] = partnerAck; // [RULE5]
      setVec[POS_IRQ_PARDET] = parallelFault; // [RULE5]
      setVec[POS_IRQ_PAGE] = pageReceived; // [RULE5]
   end

   // ****************************************************************
   // Interrupt source flags
   // ****************************************************************
   logic [7:0] flags_reg;
   logic [7:0] flags_next;
   logic [7:0] clrVec;
   logic [31:0] prdata_reg;

   // Only bits the host actually saw are cleared, so an event landing
   // between setup and access is kept; a write of ones also clears
   always_comb begin
      clrVec = 8'h00;
      if (rdAccess && isReg(paddr, ADDR_IRQ_FLAGS)) begin
         clrVec = prdata_reg[7:0]; // [RULE11]
      end
      if (wrAccess && isReg(paddr, ADDR_IRQ_FLAGS)) begin
         clrVec = clrVec | pwdata[7:0];
      end
      // Set beats clear in the same cycle
      flags_next = (flags_reg & ~clrVec) | setVec; // [RULE11]
      flags_next[0] = 1'b0; // [RULE5]
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst || softRst) begin
         flags_reg <= FLAGS_RESET;
      end else begin
         flags_reg <= flags_next; // [RULE4]
      end
   end

   // Level output straight from registered state
   assign irqOut = |(flags_reg & mask_reg); // [RULE12]

   // ****************************************************************
   // Read data
   // ****************************************************************

   // Captured in the setup cycle so prdata comes from a flip-flop
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         prdata_reg <= 32'h0000_0000;
      end else if (setupPhase && !pwrite) begin
         prdata_reg <= 32'h0000_0000;
         if (isReg(paddr, ADDR_SPECIAL_CTRL)) begin
            prdata_reg[POS_PLL_FORCE] <= pllForce_reg;
            prdata_reg[POS_POLARITY] <= polarity_reg; // [RULE2]
            prdata_reg[3:0] <= CTRL_FIXED_LOW; // [RULE3]
         end
         if (isReg(paddr, ADDR_IRQ_FLAGS)) begin
            prdata_reg[7:0] <= flags_reg;
         end
         if (isReg(paddr, ADDR_IRQ_MASK)) begin
            prdata_reg[7:0] <= mask_reg; // [RULE6]
         end
         if (isReg(paddr, ADDR_PHY_STATUS)) begin
            prdata_reg[POS_AUTODONE] <= autodone_reg; // [RULE7]
            prdata_reg[POS_STS_RSV_LSB +: 7] <= stsRsv_reg;
            prdata_reg[POS_SPEED_LSB +: 3] <= speed_reg; // [RULE8]
         end
      end
   end

   assign prdata = prdata_reg;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   logic rdSetupCtrl;
   logic rdSetupMask;
   logic rdSetupSts;
   assign rdSetupCtrl = setupPhase && !pwrite &&
                        isReg(paddr, ADDR_SPECIAL_CTRL);
   assign rdSetupMask = setupPhase && !pwrite && isReg(paddr, ADDR_IRQ_MASK);
   assign rdSetupSts = setupPhase && !pwrite && isReg(paddr, ADDR_PHY_STATUS);

   chk_pll_write: assert property ( // [RULE1]
      wrAccess && isReg(paddr, ADDR_SPECIAL_CTRL) |=>
      rxPllRefLockForce == $past(pwdata[POS_PLL_FORCE]) &&
      rx10mReceiveEnable != rxPllRefLockForce)
      else $error("PLL force bit not applied by write");
   chk_polarity_read: assert property ( // [RULE2]
      rdSetupCtrl |=> prdata[POS_POLARITY] == $past(polarityReversed, 2))
      else $error("polarity bit does not follow line state");
   chk_fixed_bits: assert property ( // [RULE3]
      rdSetupCtrl |=> prdata[3:0] == 4'hB && prdata[15:11] == 5'h00)
      else $error("fixed control bits read wrong");
   chk_flag_latch: assert property ( // [RULE4]
      setVec != 8'h00 && !softRst |=>
      (flags_reg & $past(setVec)) == $past(setVec))
      else $error("interrupt event not latched");
   chk_flag_rsvd: assert property ( // [RULE5]
      flags_reg[0] == 1'b0 && (!$past(rdSetupMask) || prdata_reg[31:8] == '0))
      else $error("reserved source bit set");
   chk_mask_upper: assert property ( // [RULE6]
      rdSetupMask |=> prdata[31:8] == 24'h000000 && prdata[7:0] == mask_reg)
      else $error("mask read back wrong");
   chk_autodone_read: assert property ( // [RULE7]
      rdSetupSts |=> prdata[POS_AUTODONE] == $past(autonegDone, 2))
      else $error("autodone bit does not follow negotiation");
   chk_speed_read: assert property ( // [RULE8]
      rdSetupSts |=> prdata[4:2] == $past(speedDuplex, 2) &&
      prdata[1:0] == 2'b00)
      else $error("speed code read wrong");
   chk_flag_hold: assert property ( // [RULE11]
      flags_reg[POS_IRQ_PAGE] && !accessPhase && !softRst |=>
      flags_reg[POS_IRQ_PAGE])
      else $error("source flag lost without a read");
   chk_read_clear: assert property ( // [RULE11]
      rdAccess && isReg(paddr, ADDR_IRQ_FLAGS) && prdata[POS_IRQ_ACK] &&
      !partnerAck && !softRst |=> !flags_reg[POS_IRQ_ACK])
      else $error("read flag not cleared");
   chk_irq_masked: assert property ( // [RULE12]
      wrAccess && isReg(paddr, ADDR_IRQ_MASK) && pwdata[7:0] == 8'h00 |=>
      !irqOut)
      else $error("interrupt with all sources masked");
   chk_unmapped_err: assert property (
      accessPhase && !mapped |-> pslverr && pready)
      else $error("unmapped access not refused");

   cov_irq_rise: cover property ($rose(irqOut));
   cov_flag_cleared: cover property (
      rdAccess && isReg(paddr, ADDR_IRQ_FLAGS) && prdata[7:1] != '0);
   cov_pll_forced: cover property ($rose(rxPllRefLockForce));
   cov_set_on_clear: cover property ((clrVec & setVec) != 8'h00);

endmodule
`default_nettype wire

//--- verif/pvs_mgmt_master.sv
// Management-side APB master model that reaches the PHY registers
`timescale 1ns/10ps
`default_nettype none
module pvs_mgmt_master
   import pvs_pkg::*;
(
   // Clock
   input wire logic clk_sys,
   // APB request
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [ADDR_W-1:0] paddr,
   output logic [31:0] pwdata,
   // APB answer
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr
);
   // ****************************************************************
   // Idle bus from time zero
   // ****************************************************************
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = 32'h0000_0000;
   end

   // ****************************************************************
   // One transfer: setup, then access until ready at a rising edge
   // ****************************************************************
   // No fixed latency assumed; only the bench ceiling ends a stall
   task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
      input logic [31:0] wd, output logic [31:0] rd, output logic err);
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule
`default_nettype wire

//--- verif/tb_top.sv
// Self-checking bench for the PHY vendor status and interrupt registers
`timescale 1ns/10ps
`default_nettype none
module tb_top
   import pvs_pkg::*;
;
   // ****************************************************************
   // Signals and instances
   // ****************************************************************
   localparam int TMO = 20;
   logic clk_sys, nrst, softRst, psel, penable, pwrite, pready, pslverr;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata;
   logic lineEnergySeen, polarityReversed, autonegDone, remoteFault;
   logic linkUp, partnerAck, parallelFault, pageReceived;
   logic [2:0] speedDuplex;
   logic rxPllRefLockForce, rx10mReceiveEnable, lineEnergyPresent, irqOut;
   int error_cnt = 0;
   int cmp_count = 0;
   int cyc = 0;
   logic [2:0] spd [4] = '{SPD_10_HALF, SPD_10_FULL, SPD_100_HALF,
      SPD_100_FULL};

   // Short quiet period keeps the energy watchdog test brief
   pvs_regs #(.ENERGY_TIMEOUT_CYCLES(TMO)) u_dut (.clk_sys(clk_sys),
      .nrst(nrst), .softRst(softRst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .lineEnergySeen(lineEnergySeen),
      .polarityReversed(polarityReversed), .autonegDone(autonegDone),
      .speedDuplex(speedDuplex), .remoteFault(remoteFault),
      .linkUp(linkUp), .partnerAck(partnerAck),
      .parallelFault(parallelFault), .pageReceived(pageReceived),
      .rxPllRefLockForce(rxPllRefLockForce),
      .rx10mReceiveEnable(rx10mReceiveEnable),
      .lineEnergyPresent(lineEnergyPresent), .irqOut(irqOut));
   pvs_mgmt_master u_mgmt (.clk_sys(clk_sys), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready), .prdata(prdata), .pslverr(pslverr));

   // ****************************************************************
   // Clock, ceiling and helpers
   // ****************************************************************
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   // A hung transfer counts as a mismatch
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         test_done();
      end
   end

   task automatic chk(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic rdchk(input string nm, input logic [ADDR_W-1:0] a,
      input logic [31:0] exp);
      logic [31:0] d;
      logic e;
      u_mgmt.xfer(1'b0, a, 32'h0000_0000, d, e);
      chk(nm, d, exp);
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      u_mgmt.xfer(1'b1, a, d, r, e);
   endtask

   // One-cycle event on the chosen source, then let it settle
   task automatic pulse(input int b);
      @(posedge clk_sys);
      case (b)
         5: remoteFault <= 1'b1;
         4: linkUp <= 1'b0;
         3: partnerAck <= 1'b1;
         2: parallelFault <= 1'b1;
         1: pageReceived <= 1'b1;
         default: autonegDone <= 1'b1;
      endcase
      @(posedge clk_sys);
      remoteFault <= 1'b0;
      linkUp <= 1'b1;
      partnerAck <= 1'b0;
      parallelFault <= 1'b0;
      pageReceived <= 1'b0;
      autonegDone <= 1'b0;
      repeat (3) @(posedge clk_sys);
   endtask

   task automatic test_done();
      $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // ****************************************************************
   // Test sequence
   // ****************************************************************
   initial begin
      logic [31:0] d;
      logic e;
      nrst = 1'b0;
      softRst = 1'b0;
      lineEnergySeen = 1'b1;
      polarityReversed = 1'b0;
      autonegDone = 1'b0;
      speedDuplex = SPD_10_HALF;
      remoteFault = 1'b0;
      linkUp = 1'b1;
      partnerAck = 1'b0;
      parallelFault = 1'b0;
      pageReceived = 1'b0;
      repeat (10) @(posedge clk_sys);
      nrst <= 1'b1;
      // Reset values
      rdchk("ctrl", ADDR_SPECIAL_CTRL, 32'h0000_000B);
      rdchk("mask", ADDR_IRQ_MASK, 32'h0000_0000);
      rdchk("status", ADDR_PHY_STATUS, 32'h0000_0044);
      chk("energy", {31'h0, lineEnergyPresent}, 32'h1);
      chk("irq", {31'h0, irqOut}, 32'h0);
      $display("reset test done");
      // Control: force bit, fixed low nibble, polarity
      wr(ADDR_SPECIAL_CTRL, 32'hFFFF_FFFF);
      rdchk("ctrl", ADDR_SPECIAL_CTRL, 32'h0000_040B);
      chk("force", {31'h0, rxPllRefLockForce}, 32'h1);
      chk("rx10", {31'h0, rx10mReceiveEnable}, 32'h0);
      polarityReversed <= 1'b1;
      rdchk("ctrl", ADDR_SPECIAL_CTRL, 32'h0000_041B);
      wr(ADDR_SPECIAL_CTRL, 32'h0000_0000);
      polarityReversed <= 1'b0;
      rdchk("ctrl", ADDR_SPECIAL_CTRL, 32'h0000_000B);
      chk("rx10", {31'h0, rx10mReceiveEnable}, 32'h1);
      wr(ADDR_IRQ_MASK, 32'hFFFF_FFFF);
      rdchk("mask", ADDR_IRQ_MASK, 32'h0000_00FF);
      $display("control test done");
      // Status: every speed code with negotiation finished
      for (int i = 0; i < 4; i++) begin
         speedDuplex <= spd[i];
         autonegDone <= 1'b1;
         wr(ADDR_PHY_STATUS, {20'h0, STS_RSV_RESET, 5'h00});
         rdchk("status", ADDR_PHY_STATUS,
            {19'h0, 1'b1, STS_RSV_RESET, spd[i], 2'b00});
      end
      autonegDone <= 1'b0;
      rdchk("status", ADDR_PHY_STATUS,
         {19'h0, 1'b0, STS_RSV_RESET, SPD_100_FULL, 2'b00});
      $display("status test done");
      // Each latched source but energy, read clears it
      u_mgmt.xfer(1'b0, ADDR_IRQ_FLAGS, 32'h0000_0000, d, e);
      for (int b = 1; b < 7; b++) begin
         pulse(b);
         chk("irq", {31'h0, irqOut}, 32'h1);
         rdchk("flags", ADDR_IRQ_FLAGS, 32'h1 << b);
         rdchk("flags", ADDR_IRQ_FLAGS, 32'h0);
         @(posedge clk_sys);
         chk("irq", {31'h0, irqOut}, 32'h0);
      end
      // A condition still present survives the read
      linkUp <= 1'b0;
      repeat (3) @(posedge clk_sys);
      rdchk("flags", ADDR_IRQ_FLAGS, 32'h0000_0010);
      rdchk("flags", ADDR_IRQ_FLAGS, 32'h0000_0010);
      linkUp <= 1'b1;
      u_mgmt.xfer(1'b0, ADDR_IRQ_FLAGS, 32'h0000_0000, d, e);
      // Masked source keeps the output low until enabled
      wr(ADDR_IRQ_MASK, 32'h0000_0000);
      pulse(5);
      chk("irq", {31'h0, irqOut}, 32'h0);
      wr(ADDR_IRQ_MASK, 32'h0000_0020);
      @(posedge clk_sys);
      chk("irq", {31'h0, irqOut}, 32'h1);
      u_mgmt.xfer(1'b0, ADDR_IRQ_FLAGS, 32'h0000_0000, d, e);
      $display("interrupt test done");
      // Energy watchdog falls, returning energy latches a source
      lineEnergySeen <= 1'b0;
      repeat (TMO + 5) @(posedge clk_sys);
      chk("energy", {31'h0, lineEnergyPresent}, 32'h0);
      lineEnergySeen <= 1'b1;
      repeat (3) @(posedge clk_sys);
      chk("energy", {31'h0, lineEnergyPresent}, 32'h1);
      rdchk("flags", ADDR_IRQ_FLAGS, 32'h0000_0080);
      $display("energy test done");
      // Soft reset clears the mask, keeps PLL force and energy status
      wr(ADDR_SPECIAL_CTRL, 32'h0000_0400);
      wr(ADDR_IRQ_MASK, 32'h0000_00FF);
      @(posedge clk_sys);
      softRst <= 1'b1;
      @(posedge clk_sys);
      softRst <= 1'b0;
      rdchk("mask", ADDR_IRQ_MASK, 32'h0000_0000);
      rdchk("ctrl", ADDR_SPECIAL_CTRL, 32'h0000_040B);
      chk("energy", {31'h0, lineEnergyPresent}, 32'h1);
      chk("irq", {31'h0, irqOut}, 32'h0);
      $display("soft reset test done");
      // Unmapped address is refused
      u_mgmt.xfer(1'b0, 8'h00, 32'h0000_0000, d, e);
      chk("slverr", {31'h0, e}, 32'h1);
      chk("unmapped", d, 32'h0000_0000);
      $display("unmapped test done");
      test_done();
   end
endmodule
`default_nettype wire
